// ### hw/wct_pkg.sv
// Package with constants and types for the weekly cam timer
package wct_pkg;
  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_CAMS = 3;
  localparam int DAYS = 7;
  localparam int HOUR_W = 5;
  localparam int MIN_W = 6;
  localparam int TIME_W = HOUR_W + MIN_W;
  // ************************************************************
  // Time-of-day limits and encodings
  // ************************************************************
  localparam logic [HOUR_W-1:0] LAST_HOUR = 5'h17;
  localparam logic [MIN_W-1:0] LAST_MIN = 6'h3b;
  localparam logic [TIME_W-1:0] TIME_UNSET = 11'h7ff;
  localparam logic [TIME_W-1:0] TIME_MIDNIGHT = 11'h000;
  localparam logic [DAYS-1:0] DAYS_NONE = 7'h00;
  localparam logic [2:0] WDAY_LAST = 3'h6;
  localparam logic RESET_LEVEL = 1'b0;

  // Action requested by one cam in the current minute
  typedef enum logic [1:0] {
    WCT_ACT_NONE,
    WCT_ACT_ON,
    WCT_ACT_OFF
  } wct_act_t;
endpackage : wct_pkg

// ### hw/wct_cam_store.sv
// Small memory holding the settings of all cams
`timescale 1ns/1ps
module wct_cam_store #(
  parameter int N = wct_pkg::NUM_CAMS,
  parameter int W = wct_pkg::DAYS + 2 * wct_pkg::TIME_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  // Registered read of every entry, flattened
  output logic [N*W-1:0] rd_data_q
);
  logic [W-1:0] mem_q [N];

  // Storage, unset times and no days after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        mem_q[i] <= {wct_pkg::DAYS_NONE, wct_pkg::TIME_UNSET,
                     wct_pkg::TIME_UNSET};
      end
    end else if (wr_en && (int'(wr_idx) < N)) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // Read register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        rd_data_q[i*W +: W] <= mem_q[i];
      end
    end
  end
endmodule : wct_cam_store

// ### hw/wct_timer.sv
// Weekly timer with three cams driving one output
`timescale 1ns/1ps
// Operation
// - Three cams, each with on and off time, drive one output.
// - Each cam keeps its own weekdays and times.
// - On-time match on active day sets output; set stays set.
// - Off-time match on active day clears output; clear stays clear.
// - Conflicts resolved: third cam beats second, second beats first.
// - Output level follows the combined actions of all cams.
// - Seven weekday flags per cam; only selected days act.
// - Times are hour:minute from 00:00 to 23:59.
// - An unset time gives no switching action.
// - Function is present only when a real-time clock exists.
module wct_timer #(
  parameter bit HAS_RTC = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Real-time clock: weekday 0=Monday..6=Sunday, hour, minute
  input wire logic [2:0] rtc_wday,
  input wire logic [wct_pkg::HOUR_W-1:0] rtc_hour,
  input wire logic [wct_pkg::MIN_W-1:0] rtc_min,
  input wire logic rtc_valid,
  // Cam configuration: days bit0=Monday, times as hour,minute
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_cam,
  input wire logic [wct_pkg::DAYS-1:0] cfg_days,
  input wire logic [wct_pkg::TIME_W-1:0] cfg_on_time,
  input wire logic [wct_pkg::TIME_W-1:0] cfg_off_time,
  // Output and status
  output logic switch_q,
  output logic event_q,
  output logic cfg_err_q
);
  localparam int N = wct_pkg::NUM_CAMS;
  localparam int TW = wct_pkg::TIME_W;
  localparam int W = wct_pkg::DAYS + 2 * TW;

  // ************************************************************
  // Helpers
  // ************************************************************
  // A time is usable when it lies within one day
  function automatic logic time_ok(input logic [TW-1:0] t);
    time_ok = (t[TW-1:wct_pkg::MIN_W] <= wct_pkg::LAST_HOUR) &&
              (t[wct_pkg::MIN_W-1:0] <= wct_pkg::LAST_MIN);
  endfunction : time_ok

  // Setting is either a valid time or the unset marker
  function automatic logic setting_ok(input logic [TW-1:0] t);
    setting_ok = time_ok(t) || (t == wct_pkg::TIME_UNSET);
  endfunction : setting_ok

  // ************************************************************
  // Cam storage
  // ************************************************************
  logic [N*W-1:0] cams;
  logic cfg_good;

  assign cfg_good = setting_ok(cfg_on_time) && setting_ok(cfg_off_time) &&
                    (int'(cfg_cam) < N);

  // Each cam keeps its own days and times
  wct_cam_store #(
    .N(N),
    .W(W)
  ) u_store (
    .clock(clock),
    .rst(rst),
    .wr_en(cfg_wr && cfg_good),
    .wr_idx(cfg_cam),
    .wr_data({cfg_days, cfg_on_time, cfg_off_time}),
    .rd_data_q(cams)
  );

  // Rejected configuration flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_err_q <= 1'b0;
    end else if (cfg_wr) begin
      cfg_err_q <= !cfg_good;
    end
  end

  // ************************************************************
  // Minute tracking
  // ************************************************************
  logic [TW-1:0] now;
  logic [TW-1:0] last_min_q;
  logic seen_q;
  logic new_min;
  logic now_ok;

  assign now = {rtc_hour, rtc_min};
  assign now_ok = rtc_valid && time_ok(now) &&
                  (rtc_wday <= wct_pkg::WDAY_LAST);
  assign new_min = now_ok && (!seen_q || (now != last_min_q));

  // Remember the minute already acted upon
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_min_q <= wct_pkg::TIME_MIDNIGHT;
      seen_q <= 1'b0;
    end else if (new_min) begin
      last_min_q <= now;
      seen_q <= 1'b1;
    end
  end

  // ************************************************************
  // Cam evaluation and priority
  // ************************************************************
  wct_pkg::wct_act_t act [N];
  wct_pkg::wct_act_t win;

  // Per-cam action for this minute
  always_comb begin
    for (int i = 0; i < N; i++) begin
      logic [W-1:0] c;
      logic day_on;
      c = cams[i*W +: W];
      day_on = c[2*TW + 32'(rtc_wday)];
      act[i] = wct_pkg::WCT_ACT_NONE;
      if (day_on && c[2*TW-1:TW] != wct_pkg::TIME_UNSET &&
          c[2*TW-1:TW] == now) begin
        act[i] = wct_pkg::WCT_ACT_ON;
      end
      if (day_on && c[TW-1:0] != wct_pkg::TIME_UNSET &&
          c[TW-1:0] == now) begin
        act[i] = wct_pkg::WCT_ACT_OFF; // Same cam: off wins
      end
    end
  end

  // Highest-numbered active cam decides
  always_comb begin
    win = wct_pkg::WCT_ACT_NONE;
    for (int i = 0; i < N; i++) begin
      if (act[i] != wct_pkg::WCT_ACT_NONE) begin
        win = act[i];
      end
    end
  end

  // ************************************************************
  // Output register
  // ************************************************************
  // Output changes only on a switching event
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      switch_q <= wct_pkg::RESET_LEVEL;
      event_q <= 1'b0;
    end else begin
      event_q <= 1'b0;
      if (HAS_RTC && new_min) begin
        case (win)
          wct_pkg::WCT_ACT_ON: begin
            switch_q <= 1'b1;
            event_q <= 1'b1;
          end
          wct_pkg::WCT_ACT_OFF: begin
            switch_q <= 1'b0;
            event_q <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_hold;
    @(posedge clock) disable iff (rst)
      !event_q |-> $stable(switch_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed without event");

  property p_once;
    @(posedge clock) disable iff (rst)
      event_q && $stable(now) && $stable(rtc_valid) ##1 $stable(now)
      |-> !event_q;
  endproperty
  a_once: assert property (p_once)
    else $error("second event within one minute");

  property p_on;
    @(posedge clock) disable iff (rst)
      HAS_RTC && new_min && win == wct_pkg::WCT_ACT_ON |=> switch_q;
  endproperty
  a_on: assert property (p_on)
    else $error("on match did not set output");

  property p_off;
    @(posedge clock) disable iff (rst)
      HAS_RTC && new_min && win == wct_pkg::WCT_ACT_OFF |=> !switch_q;
  endproperty
  a_off: assert property (p_off)
    else $error("off match did not clear output");

  property p_prio;
    @(posedge clock) disable iff (rst)
      HAS_RTC && new_min && act[2] == wct_pkg::WCT_ACT_OFF
      |=> !switch_q;
  endproperty
  a_prio: assert property (p_prio)
    else $error("third cam off did not win");

  property p_prio2;
    @(posedge clock) disable iff (rst)
      HAS_RTC && new_min && act[2] == wct_pkg::WCT_ACT_NONE &&
      act[1] == wct_pkg::WCT_ACT_ON |=> switch_q;
  endproperty
  a_prio2: assert property (p_prio2)
    else $error("second cam on did not win over first");

  property p_invalid;
    @(posedge clock) disable iff (rst)
      !now_ok |=> !event_q;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("event from invalid time");

  property p_nortc;
    @(posedge clock) disable iff (rst)
      !HAS_RTC |-> !switch_q && !event_q;
  endproperty
  a_nortc: assert property (p_nortc)
    else $error("output active without clock variant");
endmodule : wct_timer

// ### test/wct_rtc_model.sv
// Real-time clock model that feeds weekday and time of day
`timescale 1ns/1ps
module wct_rtc_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Time setting from the bench
  input wire logic [2:0] set_wday,
  input wire logic [10:0] set_time,
  // Clock outputs
  output logic [2:0] rtc_wday,
  output logic [4:0] rtc_hour,
  output logic [5:0] rtc_min,
  output logic rtc_valid
);
  // Present the set time one edge later, valid once out of reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rtc_wday <= 3'h0;
      rtc_hour <= 5'h00;
      rtc_min <= 6'h00;
      rtc_valid <= 1'b0;
    end else begin
      rtc_wday <= set_wday;
      rtc_hour <= set_time[10:6];
      rtc_min <= set_time[5:0];
      rtc_valid <= 1'b1;
    end
  end
endmodule : wct_rtc_model

// ### test/weekly_cam_timer_test.sv
// Self-checking bench for the weekly cam timer
`timescale 1ns/1ps
module weekly_cam_timer_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr = 1'b0;
  logic [1:0] cfg_cam = 2'h0;
  logic [6:0] cfg_days = 7'h00;
  logic [10:0] cfg_on_time = 11'h7ff;
  logic [10:0] cfg_off_time = 11'h7ff;
  logic [2:0] set_wday = 3'h0;
  logic [10:0] set_time = 11'h000;
  logic [2:0] rtc_wday;
  logic [4:0] rtc_hour;
  logic [5:0] rtc_min;
  logic rtc_valid, switch_q, event_q, cfg_err_q;
  int errors = 0;
  int n_tests = 0;
  int n_ev = 0;
  int cyc = 0;
  // Rows: weekday, time, expected output, expected event
  localparam logic [15:0] ROWS [10] = '{
    {3'h0, 11'h15d, 2'b00}, {3'h0, 11'h15e, 2'b11}, {3'h0, 11'h180, 2'b10},
    {3'h0, 11'h1e8, 2'b01}, {3'h1, 11'h0ca, 2'b11}, {3'h1, 11'h10f, 2'b01},
    {3'h2, 11'h0ca, 2'b00}, {3'h5, 11'h41e, 2'b11}, {3'h5, 11'h5ca, 2'b01},
    {3'h4, 11'h41e, 2'b00}};

  wct_timer #(.HAS_RTC(1'b1)) u_dut (.clock, .rst, .rtc_wday, .rtc_hour,
    .rtc_min, .rtc_valid, .cfg_wr, .cfg_cam, .cfg_days, .cfg_on_time,
    .cfg_off_time, .switch_q, .event_q, .cfg_err_q);
  wct_rtc_model u_rtc (.clock, .rst, .set_wday, .set_time, .rtc_wday,
    .rtc_hour, .rtc_min, .rtc_valid);

  // 40 MHz clock
  initial begin
    forever #12.5 clock = ~clock;
  end

  // Event pulse counter and run ceiling
  always @(posedge clock) begin
    cyc++;
    if (event_q === 1'b1) n_ev++;
    if (cyc == 5000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // One cam write, then wait for it to take effect
  task automatic cfg(input logic [1:0] c, input logic [6:0] d,
                     input logic [10:0] on_t, input logic [10:0] off_t);
    @(posedge clock);
    cfg_wr <= 1'b1;
    cfg_cam <= c;
    cfg_days <= d;
    cfg_on_time <= on_t;
    cfg_off_time <= off_t;
    @(posedge clock);
    cfg_wr <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : cfg

  // Move the clock to a new minute and check output and event
  task automatic at(input logic [2:0] wd, input logic [10:0] t,
                    input logic sw, input logic ev);
    int n0;
    n0 = n_ev;
    @(posedge clock);
    set_wday <= wd;
    set_time <= t;
    repeat (4) @(posedge clock);
    #1;
    chk("switch", sw, switch_q);
    chk("event", ev, (n_ev - n0) == 1);
    chk("event count", 1'b1, (n_ev - n0) <= 1);
  endtask : at

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk("switch", 1'b0, switch_q);
    chk("event", 1'b0, event_q);
    cfg(2'h0, 7'h7f, 11'h15e, 11'h1e8);
    cfg(2'h1, 7'h02, 11'h0ca, 11'h10f);
    cfg(2'h2, 7'h60, 11'h41e, 11'h5ca);
    chk("cfg_err", 1'b0, cfg_err_q);
    for (int i = 0; i < 10; i++) begin
      at(ROWS[i][15:13], ROWS[i][12:2], ROWS[i][1], ROWS[i][0]);
    end
    $display("test rows done");
    cfg(2'h1, 7'h01, 11'h7ff, 11'h280);
    cfg(2'h2, 7'h01, 11'h280, 11'h7ff);
    at(3'h0, 11'h280, 1'b1, 1'b1);
    cfg(2'h1, 7'h01, 11'h300, 11'h7ff);
    cfg(2'h2, 7'h01, 11'h7ff, 11'h300);
    at(3'h0, 11'h300, 1'b0, 1'b1);
    cfg(2'h0, 7'h01, 11'h7ff, 11'h340);
    cfg(2'h1, 7'h01, 11'h340, 11'h7ff);
    cfg(2'h2, 7'h7f, 11'h000, 11'h5fb);
    at(3'h0, 11'h340, 1'b1, 1'b1);
    at(3'h0, 11'h5fb, 1'b0, 1'b1);
    at(3'h1, 11'h000, 1'b1, 1'b1);
    cfg(2'h2, 7'h7f, 11'h7ff, 11'h7ff);
    at(3'h2, 11'h5fb, 1'b1, 1'b0);
    $display("test conflicts done");
    cfg(2'h3, 7'h7f, 11'h000, 11'h000);
    chk("cfg_err", 1'b1, cfg_err_q);
    cfg(2'h0, 7'h7f, 11'h600, 11'h7ff);
    chk("cfg_err", 1'b1, cfg_err_q);
    cfg(2'h0, 7'h7f, 11'h380, 11'h03c);
    chk("cfg_err", 1'b1, cfg_err_q);
    at(3'h3, 11'h380, 1'b1, 1'b0);
    cfg(2'h0, 7'h01, 11'h7ff, 11'h340);
    chk("cfg_err", 1'b0, cfg_err_q);
    $display("test refusals done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk("switch", 1'b0, switch_q);
    @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("switch", 1'b0, switch_q);
    chk("event", 1'b0, event_q);
    at(3'h0, 11'h340, 1'b0, 1'b0);
    $display("test reset done");
    close_out();
  end
endmodule : weekly_cam_timer_test
